// *** shared/osd_cmd_pkg.sv ***
/*
 * Shared constants, types and register map of the serial command decoder
 * of an on-screen character display.
 * Assumes a 100 MHz bus clock; every user writes osd_cmd_pkg::name.
 */
`default_nettype none

package osd_cmd_pkg;

    // ********************************
    // Timing
    // ********************************
    localparam int CLK_PERIOD_NS = 10;     // Bus clock period
    localparam int FORMAT_SETTLE_NS = 40;  // Least settle time after a format command
    localparam int FORMAT_SETTLE_CYC = (FORMAT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ********************************
    // Screen geometry
    // ********************************
    localparam int LINES = 12;             // Display lines
    localparam int COLUMNS = 24;           // Characters per line
    localparam int CELLS = 288;            // Character cells in memory
    localparam int CELL_AW = 9;            // Cell address width
    localparam int FULL_GLYPHS = 256;      // Variant with two glyph banks

    // ********************************
    // Register map (byte offsets)
    // ********************************
    localparam logic [7:0] REG_CURSOR = 8'h00;   // Cursor and attribute, read only
    localparam logic [7:0] REG_DISPLAY = 8'h04;  // Display settings, read only
    localparam logic [7:0] REG_STATUS = 8'h08;   // Busy flag and shift word, read only
    localparam logic [7:0] REG_RAM_ADDR = 8'h0C; // Readback cell address, read/write
    localparam logic [7:0] REG_RAM_DATA = 8'h10; // Cell at readback address, read only
    localparam int STATUS_BUSY_BIT = 16;         // Busy flag position in status
    localparam logic [CELL_AW-1:0] RAM_ADDR_RST = 9'h000; // Readback address reset

    // ********************************
    // Types
    // ********************************
    // One character cell as stored
    typedef struct packed {
        logic blink;
        logic [2:0] rgb;
        logic bank;
        logic [6:0] code;
    } cell_s;

    // Cursor and current character attribute
    typedef struct packed {
        logic blink;
        logic [2:0] rgb;
        logic [3:0] line_number_field;
        logic [4:0] column_number_field;
    } cursor_s;

    // Display settings, exactly 32 bits
    typedef struct packed {
        logic [3:0] test_mode;
        logic [5:0] char_size;
        logic [4:0] hpos;
        logic [4:0] vpos;
        logic [4:0] background;
        logic format_flag;
        logic frame_edge;
        logic bank_sel;
        logic dot_clock_run;
        logic [1:0] flash_ratio_sel;
        logic display_on;
    } settings_s;

    localparam settings_s SETTINGS_RST = '0;      // Settings after reset

    // Decoded command kinds
    typedef enum logic [3:0] {
        CMD_NONE, CMD_CHAR, CMD_ATTR, CMD_LINE, CMD_COL, CMD_BACK, CMD_DISP,
        CMD_BANK, CMD_FRAME, CMD_FORMAT, CMD_VPOS, CMD_HPOS, CMD_SIZE, CMD_TEST
    } cmd_e;

    // Execution states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOLD = 3'b010,
        ST_CLEAR = 3'b100
    } state_e;

endpackage

`default_nettype wire

// *** logic/cell_ram.sv ***
/*
 * Simple dual-port character cell memory with a registered read port.
 * Assumes one clock; write and read addresses come from the same domain.
 */
`timescale 1ns/1ps
`default_nettype none

module cell_ram #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 288,
    parameter int AW = 9
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    // ********************************
    // Storage
    // ********************************
    if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad_depth
        $error("cell_ram depth does not fit the address width");
    end

    logic [WIDTH-1:0] mem [DEPTH];  // Cell array, no reset

    // Write, then registered read
    always_ff @(posedge clk) begin
        if (we && waddr < AW'(DEPTH)) begin
            mem[waddr] <= wdata;
        end
        rdata <= (raddr < AW'(DEPTH)) ? mem[raddr] : '0;
    end

endmodule

`default_nettype wire

// *** logic/osd_serial_command_decoder.sv ***
/*
 * Serial command decoder of an on-screen character display: shifts in
 * host command words, executes them on the strobe, keeps the cursor,
 * the display settings and the character memory, reports busy.
 * Assumes serial pins are asynchronous to pclk and far slower than it;
 * APB master on pclk.
 */
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module osd_serial_command_decoder #(
    parameter int NUM_GLYPHS = 256
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial command pins
    input wire logic sclk,
    input wire logic sdata,
    input wire logic command_strobe,
    output logic busy,
    // Settings to the display engine
    output osd_cmd_pkg::settings_s settings
);

    // ********************************
    // Elaboration checks
    // ********************************
    if (NUM_GLYPHS != 64 && NUM_GLYPHS != 128 && NUM_GLYPHS != 256) begin : g_bad_glyphs
        $error("NUM_GLYPHS must be 64, 128 or 256");
    end

    localparam bit FULL = (NUM_GLYPHS == osd_cmd_pkg::FULL_GLYPHS); // Two banks, clearable memory
    localparam int AW = osd_cmd_pkg::CELL_AW;
    localparam logic [AW-1:0] LAST_CELL = AW'(osd_cmd_pkg::CELLS - 1);
    localparam logic [4:0] LAST_COL = 5'(osd_cmd_pkg::COLUMNS - 1);
    localparam logic [3:0] LAST_LINE = 4'(osd_cmd_pkg::LINES - 1);
    localparam logic [2:0] SETTLE_LOAD = 3'(osd_cmd_pkg::FORMAT_SETTLE_CYC - 1);
    localparam osd_cmd_pkg::state_e ST_RST = FULL ? osd_cmd_pkg::ST_CLEAR : osd_cmd_pkg::ST_IDLE;

    // ********************************
    // Functions
    // ********************************
    // Classify a command word under the current format flag
    function automatic osd_cmd_pkg::cmd_e classify(input logic [7:0] w, input logic f);
        osd_cmd_pkg::cmd_e k;
        k = osd_cmd_pkg::CMD_NONE;
        if (w[7:2] == 6'h3F) begin
            k = osd_cmd_pkg::CMD_FORMAT;
        end else if (!f) begin
            if (!w[7]) k = osd_cmd_pkg::CMD_CHAR;
            else if (w[7:4] == 4'h8) k = osd_cmd_pkg::CMD_ATTR;
            else if (w[7:4] == 4'h9) k = osd_cmd_pkg::CMD_LINE;
            else if (w[7:5] == 3'h5) k = osd_cmd_pkg::CMD_COL;
            else if (w[7:5] == 3'h6) k = osd_cmd_pkg::CMD_BACK;
            else if (w[7:4] == 4'hE) k = osd_cmd_pkg::CMD_DISP;
            else if (w[7:1] == 7'h7A) k = osd_cmd_pkg::CMD_BANK;
            else if (w[7:2] == 6'h3C && !w[0]) k = osd_cmd_pkg::CMD_FRAME;
        end else begin
            if (w[7:5] == 3'h2) k = osd_cmd_pkg::CMD_VPOS;
            else if (w[7:5] == 3'h6) k = osd_cmd_pkg::CMD_HPOS;
            else if (w[7:6] == 2'h2) k = osd_cmd_pkg::CMD_SIZE;
            else if (w[7:4] == 4'hE) k = osd_cmd_pkg::CMD_TEST;
        end
        return k;
    endfunction
    // Linear cell index of a line and column
    function automatic logic [AW-1:0] cell_index(input logic [3:0] ln, input logic [4:0] col);
        return AW'({ln, 4'h0}) + AW'({ln, 3'h0}) + AW'(col);
    endfunction

    // ********************************
    // Pin synchronisers
    // ********************************
    logic [2:0] meta_r;  // First stage, read only by sync_r
    logic [2:0] sync_r;  // Second stage: strobe, data, serial clock
    logic [2:0] prev_r;  // Previous synchronised level for edges
    // Two flip-flops per pin, then one for edge finding
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
            prev_r <= 3'h0;
        end else begin
            meta_r <= {command_strobe, sdata, sclk};
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end
    wire logic sclk_rise = sync_r[0] & ~prev_r[0];  // Serial clock edge
    wire logic sdata_s = sync_r[1];                 // Data at that edge
    wire logic stb_rise = sync_r[2] & ~prev_r[2];   // Strobe rising edge

    // ********************************
    // Shift register
    // ********************************
    logic [7:0] shift_r;  // Last eight serial bits, first bit ends as bit 7
    // Shift on every serial clock rise, oldest bits fall out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_r <= 8'h00;
        end else if (sclk_rise) begin
            shift_r <= {shift_r[6:0], sdata_s};
        end
    end

    // ********************************
    // Decode and execution state
    // ********************************
    osd_cmd_pkg::settings_s settings_r;     // Display settings
    osd_cmd_pkg::state_e state_r, state_nxt;
    logic [2:0] hold_cnt_r, hold_cnt_nxt;   // Busy hold countdown
    logic [AW-1:0] clear_addr_r;            // Memory clear pointer
    logic busy_r;                           // Busy pin
    logic ram_we_r;                         // Character write pending this cycle
    logic [6:0] code_r;                     // Character code to write
    wire osd_cmd_pkg::cmd_e cmd_kind = classify(shift_r, settings_r.format_flag);
    wire logic is_format = (cmd_kind == osd_cmd_pkg::CMD_FORMAT);
    wire logic soft_reset = is_format & shift_r[0];          // Reset bit, never stored
    wire logic clearing = (state_r == osd_cmd_pkg::ST_CLEAR);
    wire logic char_go = stb_rise & (cmd_kind == osd_cmd_pkg::CMD_CHAR) & ~clearing;
    wire logic cell_done = ram_we_r & ~clearing;             // Write lands this edge
    // Next state and busy countdown
    always_comb begin
        state_nxt = state_r;
        hold_cnt_nxt = hold_cnt_r;
        unique case (state_r)
            osd_cmd_pkg::ST_IDLE, osd_cmd_pkg::ST_HOLD: begin
                if (stb_rise && soft_reset && FULL) begin
                    state_nxt = osd_cmd_pkg::ST_CLEAR;
                end else if (stb_rise) begin
                    state_nxt = osd_cmd_pkg::ST_HOLD;
                    hold_cnt_nxt = is_format ? SETTLE_LOAD : 3'h0;
                end else if (state_r == osd_cmd_pkg::ST_HOLD) begin
                    if (hold_cnt_r == 3'h0) begin
                        state_nxt = osd_cmd_pkg::ST_IDLE;
                    end else begin
                        hold_cnt_nxt = hold_cnt_r - 3'h1;
                    end
                end
            end
            osd_cmd_pkg::ST_CLEAR: begin
                // Busy until the last cell is zeroed
                if (clear_addr_r == LAST_CELL) begin
                    state_nxt = osd_cmd_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = osd_cmd_pkg::ST_IDLE;
            end
        endcase
    end

    // State, busy and the clear pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_RST;
            busy_r <= FULL;
            hold_cnt_r <= 3'h0;
            clear_addr_r <= '0;
        end else begin
            state_r <= state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            busy_r <= (state_nxt != osd_cmd_pkg::ST_IDLE);
            clear_addr_r <= (state_nxt == osd_cmd_pkg::ST_CLEAR && clearing) ? clear_addr_r + 1'b1 : '0;
        end
    end

    // Settings updated on the strobe, even while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settings_r <= osd_cmd_pkg::SETTINGS_RST;
        end else if (stb_rise) begin
            unique case (cmd_kind)
                osd_cmd_pkg::CMD_BACK: settings_r.background <= shift_r[4:0];
                osd_cmd_pkg::CMD_DISP: begin
                    settings_r.display_on <= shift_r[3];
                    settings_r.flash_ratio_sel <= shift_r[2:1];
                    settings_r.dot_clock_run <= shift_r[0];
                end
                osd_cmd_pkg::CMD_BANK: begin
                    if (FULL) settings_r.bank_sel <= shift_r[0];
                end
                osd_cmd_pkg::CMD_FRAME: settings_r.frame_edge <= shift_r[1];
                osd_cmd_pkg::CMD_FORMAT: begin
                    if (soft_reset) begin
                        settings_r.char_size <= 6'h00;
                        settings_r.test_mode <= 4'h0;
                        settings_r.format_flag <= 1'b0;
                    end else begin
                        settings_r.format_flag <= shift_r[1];
                    end
                end
                osd_cmd_pkg::CMD_VPOS: settings_r.vpos <= shift_r[4:0];
                osd_cmd_pkg::CMD_HPOS: settings_r.hpos <= shift_r[4:0];
                osd_cmd_pkg::CMD_SIZE: settings_r.char_size <= shift_r[5:0];
                osd_cmd_pkg::CMD_TEST: settings_r.test_mode <= shift_r[3:0];
                default: ; // Cursor commands and unknown words leave settings alone
            endcase
        end
    end

    // ********************************
    // Cursor and character writes
    // ********************************
    osd_cmd_pkg::cursor_s cursor_r;  // Line, column and attribute
    // Attribute and address loads; increment on the same edge as the memory write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cursor_r <= '0;
            ram_we_r <= 1'b0;
            code_r <= 7'h00;
        end else begin
            ram_we_r <= char_go;
            if (char_go) code_r <= shift_r[6:0];
            if (stb_rise && cmd_kind == osd_cmd_pkg::CMD_ATTR) begin
                cursor_r.blink <= shift_r[3];
                cursor_r.rgb <= shift_r[2:0];
            end
            if (cell_done) begin
                // Advance once per write, whatever the strobe width
                if (cursor_r.column_number_field == LAST_COL) begin
                    cursor_r.column_number_field <= 5'h00;
                    cursor_r.line_number_field <= (cursor_r.line_number_field == LAST_LINE) ?
                        4'h0 : cursor_r.line_number_field + 4'h1;
                end else begin
                    cursor_r.column_number_field <= cursor_r.column_number_field + 5'h01;
                end
            end else if (stb_rise && cmd_kind == osd_cmd_pkg::CMD_LINE) begin
                cursor_r.line_number_field <= shift_r[3:0];
            end else if (stb_rise && cmd_kind == osd_cmd_pkg::CMD_COL) begin
                cursor_r.column_number_field <= shift_r[4:0];
            end
        end
    end

    // Memory port: clearing has the port, else the pending character
    osd_cmd_pkg::cell_s cell_w;
    assign cell_w = clearing ? '0 : {cursor_r.blink, cursor_r.rgb, settings_r.bank_sel, code_r};
    wire logic ram_we = clearing | ram_we_r;
    wire logic [AW-1:0] ram_waddr = clearing ? clear_addr_r :
        cell_index(cursor_r.line_number_field, cursor_r.column_number_field);
    logic [AW-1:0] ram_raddr_r;              // Readback address from software
    logic [$bits(osd_cmd_pkg::cell_s)-1:0] ram_rdata;
    cell_ram #(
        .WIDTH($bits(osd_cmd_pkg::cell_s)),
        .DEPTH(osd_cmd_pkg::CELLS),
        .AW(AW)
    ) i_cell_ram (
        .clk(pclk),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(cell_w),
        .raddr(ram_raddr_r),
        .rdata(ram_rdata)
    );

    // ********************************
    // APB slave
    // ********************************
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    wire logic apb_go = psel & penable & ~pready_r;  // One wait state
    wire logic hit_addr = (paddr == osd_cmd_pkg::REG_RAM_ADDR);
    wire logic mapped = (paddr == osd_cmd_pkg::REG_CURSOR) | (paddr == osd_cmd_pkg::REG_DISPLAY) |
        (paddr == osd_cmd_pkg::REG_STATUS) | hit_addr | (paddr == osd_cmd_pkg::REG_RAM_DATA);
    wire logic [31:0] status_w = (32'(busy_r) << osd_cmd_pkg::STATUS_BUSY_BIT) | 32'(shift_r);
    wire logic [31:0] rd_mux =
        (paddr == osd_cmd_pkg::REG_CURSOR) ? 32'(cursor_r) :
        (paddr == osd_cmd_pkg::REG_DISPLAY) ? 32'(settings_r) :
        (paddr == osd_cmd_pkg::REG_STATUS) ? status_w :
        hit_addr ? 32'(ram_raddr_r) :
        (paddr == osd_cmd_pkg::REG_RAM_DATA) ? 32'(ram_rdata) : 32'h0000_0000;
    // Answer one cycle into the access phase; a write lands on the ready edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            ram_raddr_r <= osd_cmd_pkg::RAM_ADDR_RST;
        end else begin
            pready_r <= apb_go;
            pslverr_r <= apb_go & ~mapped;
            if (apb_go && !pwrite) prdata_r <= rd_mux;
            if (psel && penable && pready_r && pwrite && hit_addr) ram_raddr_r <= pwdata[AW-1:0];
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign busy = busy_r;
    assign settings = settings_r;

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_SHIFT_IN: assert property (sclk_rise |=> shift_r == {$past(shift_r[6:0]), $past(sdata_s)})
        else $error("serial bit not shifted in");
    AST_BUSY_RISE: assert property (stb_rise |=> busy_r) else $error("busy did not rise after strobe");
    AST_CHAR_BUSY: assert property (char_go && state_r == osd_cmd_pkg::ST_IDLE |=>
        ram_we_r && busy_r ##1 !busy_r || stb_rise)
        else $error("busy not released right after character write");
    AST_FORMAT_BUSY: assert property (stb_rise && is_format && !soft_reset && !busy_r |=>
        busy_r[*4] ##1 (!busy_r || stb_rise))
        else $error("format settle time wrong");
    AST_CHAR_DATA: assert property (char_go |=> ram_we_r && cell_w.code == $past(shift_r[6:0]))
        else $error("character code not written");
    AST_COL_STEP: assert property (cell_done && cursor_r.column_number_field != LAST_COL |=>
        cursor_r.column_number_field == $past(cursor_r.column_number_field) + 5'h01)
        else $error("column did not advance");
    AST_LINE_LOAD: assert property (stb_rise && cmd_kind == osd_cmd_pkg::CMD_LINE && !cell_done |=>
        cursor_r.line_number_field == $past(shift_r[3:0]))
        else $error("line not loaded");
    AST_SOFT_RESET: assert property (stb_rise && soft_reset |=>
        !settings_r.format_flag && settings_r.char_size == 6'h00 && settings_r.test_mode == 4'h0)
        else $error("soft reset left size, test or flag set");
    AST_DISP_LOAD: assert property (stb_rise && cmd_kind == osd_cmd_pkg::CMD_DISP |=>
        {settings_r.display_on, settings_r.flash_ratio_sel, settings_r.dot_clock_run} == $past(shift_r[3:0]))
        else $error("display word not loaded");
    AST_CLEAR_END: assert property ($rose(clearing) |-> ##[287:289] !clearing)
        else $error("memory clear length wrong");
    COV_CHAR: cover property (char_go ##2 !busy_r);
    COV_FORMAT: cover property (stb_rise && is_format && !soft_reset);
    COV_CLEAR: cover property (stb_rise && soft_reset ##1 clearing);
    COV_APB_RD: cover property (pready_r && !pwrite && paddr == osd_cmd_pkg::REG_RAM_DATA);

endmodule

`default_nettype wire

// *** testbench/host_model.sv ***
/*
 * Host controller model: shifts command words in, then strobes.
 * Assumes the device reports readiness on busy.
 */
`timescale 1ns/1ps
`default_nettype none

module host_model (
    // Serial pins
    output logic sclk,
    output logic sdata,
    output logic command_strobe,
    // Readiness
    input wire logic busy
);
    // ********************
    // Serial frames
    // ********************
    // Link clock stands still low between frames
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        command_strobe = 1'b0;
    end

    // Random leading bits, then the word MSB first, then strobe rise
    task send(input logic [7:0] w, input int extra);
        logic [15:0] bits;
        bits = {8'($urandom), w};
        for (int i = extra + 7; i >= 0; i--) begin
            sdata <= bits[i];
            #31.25 sclk <= 1'b1;
            #62.5 sclk <= 1'b0;
            #31.25;
        end
        sdata <= ~sdata; // Released line shows no stale level
        while (busy !== 1'b0) #10;
        #100 command_strobe <= 1'b1;
    endtask

    // Strobe low after a chosen width, then the least low time
    task drop(input int width);
        #(width) command_strobe <= 1'b0;
        #50;
    endtask
endmodule

`default_nettype wire

// *** testbench/tb_osd_serial_command_decoder.sv ***
/*
 * Self-checking bench: APB reads checked against a queue of notes.
 * Assumes host_model drives the serial pins.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin miscompares++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end

module tb_osd_serial_command_decoder;
    // ********************
    // Signals and helpers
    // ********************
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, sclk, sdata, command_strobe, busy;
    osd_cmd_pkg::settings_s settings, es;
    logic [32:0] notes[$], e_r;
    int miscompares = 0, n_tests = 0, hi, n;
    logic [3:0] ln, ln2;
    logic [4:0] cl, cl2, vp;
    logic [3:0] at;
    logic [6:0] cd;
    always #5 pclk = ~pclk;
    osd_serial_command_decoder #(.NUM_GLYPHS(256)) i_osd_serial_command_decoder (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
        .sdata(sdata), .command_strobe(command_strobe), .busy(busy), .settings(settings));
    host_model i_host_model (.sclk(sclk), .sdata(sdata), .command_strobe(command_strobe), .busy(busy));

    // APB transfer; a read notes its expected {pslverr, prdata} first
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        int k;
        if (!w) notes.push_back(e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1) miscompares++;
    endtask

    // One command; hi counts the cycles busy stays high
    task cmd(input logic [7:0] w, input int extra, input int width);
        int k;
        i_host_model.send(w, extra);
        k = 0;
        hi = 0;
        while (busy !== 1'b1 && k < 10) begin @(posedge pclk); k++; end
        while (busy === 1'b1 && hi < 400) begin @(posedge pclk); hi++; end
        if (k >= 10 || hi >= 400) miscompares++;
        i_host_model.drop(width);
    endtask

    // Read monitor takes the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
            e_r = notes.pop_front();
            `CHK("apb read", e_r, {pslverr, prdata})
        end
    end

    task report_and_stop;
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog
    initial begin
        #600000;
        miscompares++;
        report_and_stop();
    end

    // ********************
    // Scenarios
    // ********************
    initial begin
        void'($urandom(32'h65d397a9));
        es = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        n = 0;
        while (busy === 1'b1 && n < 400) begin @(posedge pclk); n++; end
        `CHK("clear cycles", 1, n >= osd_cmd_pkg::CELLS && n <= osd_cmd_pkg::CELLS + 1)
        apb(0, osd_cmd_pkg::REG_DISPLAY, 0, {1'b0, es});
        at = 4'($urandom);
        cmd(8'hE0 | at, 0, 30);
        {es.display_on, es.flash_ratio_sel, es.dot_clock_run} = at;
        cmd(8'hF5, 0, 30);
        es.bank_sel = 1'b1;
        at = 4'($urandom);
        ln = 4'($urandom_range(11, 0));
        cl = 5'($urandom_range(23, 20));
        cd = 7'($urandom);
        cmd(8'h80 | at, 0, 30);
        cmd(8'h90 | ln, 3, 30);
        cmd(8'hA0 | cl, 5, 30);
        cmd({1'b0, cd}, 0, 2000);
        `CHK("char busy", 1, hi)
        cl2 = (cl == 5'd23) ? 5'd0 : cl + 5'd1;
        ln2 = (cl != 5'd23) ? ln : (ln == 4'd11) ? 4'd0 : ln + 4'd1;
        apb(0, osd_cmd_pkg::REG_CURSOR, 0, {20'h0, at, ln2, cl2});
        apb(1, osd_cmd_pkg::REG_RAM_ADDR, ln * 24 + cl, 0);
        apb(0, osd_cmd_pkg::REG_RAM_DATA, 0, {21'h0, at, 1'b1, cd});
        cmd(8'hFE, 0, 30);
        `CHK("format busy", osd_cmd_pkg::FORMAT_SETTLE_CYC, hi)
        vp = 5'($urandom);
        es.format_flag = 1'b1;
        es.vpos = vp;
        es.hpos = 5'($urandom_range(31, 1));
        es.char_size = 6'($urandom);
        es.test_mode = 4'($urandom);
        cmd(8'h40 | vp, 0, 30);
        cmd(8'hC0 | es.hpos, 0, 30);
        cmd(8'h80 | es.char_size, 0, 30);
        cmd(8'hE0 | es.test_mode, 0, 30);
        apb(0, osd_cmd_pkg::REG_DISPLAY, 0, {1'b0, es});
        `CHK("settings pins", es, settings)
        cmd(8'hFD, 0, 30);
        `CHK("soft reset busy", 1, hi >= osd_cmd_pkg::CELLS && hi <= osd_cmd_pkg::CELLS + 1)
        {es.char_size, es.test_mode, es.format_flag} = '0;
        apb(0, osd_cmd_pkg::REG_DISPLAY, 0, {1'b0, es});
        `CHK("settings pins", es, settings)
        apb(1, osd_cmd_pkg::REG_RAM_ADDR, ln * 24 + cl, 0);
        apb(0, osd_cmd_pkg::REG_RAM_DATA, 0, 33'h0);
        apb(0, 8'h14, 0, {1'b1, 32'h0});
        repeat (5) @(posedge pclk);
        report_and_stop();
    end
endmodule

`default_nettype wire
